//--- src/fel_pkg.sv
// fel_pkg: shared constants, types and code table of the line coder
package fel_pkg;
  localparam logic [4:0] SYM_I = 5'h1f;
  localparam logic [4:0] SYM_J = 5'h18;
  localparam logic [4:0] SYM_K = 5'h11;
  localparam logic [4:0] SYM_T = 5'h0d;
  localparam logic [4:0] SYM_R = 5'h07;
  localparam logic [9:0] SYM_JK = 10'h311;
  localparam logic [3:0] NIB_PRE = 4'h5;
  localparam logic [2:0] SYM_LAST = 3'h4;
  localparam logic [2:0] JK_WAIT = 3'h6;
  localparam logic [4:0] LOCK_CNT = 5'h1d;
  localparam logic [10:0] SCR_SEED = 11'h7ff;
  localparam int SCR_TAP_A = 10;
  localparam int SCR_TAP_B = 8;
  localparam logic [1:0] NIB_LAST = 2'h3;
  localparam logic [4:0] ENC_TAB [16] = '{
    5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};

  typedef struct packed {
    logic last;
    logic [3:0] data;
  } fel_txw_t;

  typedef struct packed {
    logic valid;
    logic err;
    logic [3:0] data;
  } fel_rxw_t;

  typedef enum logic [1:0] {LVL_ZERO = 2'h0, LVL_POS = 2'h1, LVL_NEG = 2'h3} fel_lvl_t;

  typedef enum logic [4:0] {TX_IDLE = 5'h01, TX_K = 5'h02, TX_DATA = 5'h04,
    TX_T = 5'h08, TX_R = 5'h10} fel_txst_t;

  typedef enum logic [4:0] {RX_IDLE = 5'h01, RX_CHK = 5'h02, RX_FRAME = 5'h04,
    RX_END = 5'h08, RX_BAD = 5'h10} fel_rxst_t;

  // returns {ok, nibble}; ok low for control and invalid groups
  function automatic logic [4:0] fel_dec(input logic [4:0] sym);
    logic [4:0] res;
    res = 5'h00;
    for (int i = 0; i < 16; i++)
    begin
      if (ENC_TAB[i] == sym)
      begin
        res = {1'b1, 4'(i)};
      end
    end
    return res;
  endfunction
endpackage

//--- src/fel_line_coder.sv
// fel_line_coder: 100 Mbps 4B/5B, scrambler, MLT-3 and 10 Mbps Manchester datapath
module fel_line_coder (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic speed100_in,
  input wire logic link_ok_in,
  input wire logic tx_valid_in,
  input wire fel_pkg::fel_txw_t tx_word_in,
  output logic tx_ready_out,
  output fel_pkg::fel_lvl_t mlt_level_out,
  output logic man_level_out,
  output logic man_en_out,
  output logic man_weak_out,
  input wire fel_pkg::fel_lvl_t rx_level_in,
  input wire logic rx_man_in,
  input wire logic rx_man_act_in,
  output fel_pkg::fel_rxw_t rx_word_out,
  output logic rx_locked_out
);
  import fel_pkg::*;

  // two-entry transmit buffer
  fel_txw_t buf_r [2];
  logic [1:0] wr_ptr_r;
  logic [1:0] rd_ptr_r;
  logic pop100;
  logic pop10;
  wire logic [1:0] fill = wr_ptr_r - rd_ptr_r;
  wire logic buf_full = (fill == 2'h2);
  wire logic head_ok = (fill != 2'h0);
  wire fel_txw_t head = buf_r[rd_ptr_r[0]];
  wire logic push = clk_en_in && tx_valid_in && !buf_full;
  wire logic pop = clk_en_in && (speed100_in ? pop100 : pop10);
  assign tx_ready_out = !buf_full;

  always_ff @(posedge clk_in)
  begin
    if (push)
    begin
      buf_r[wr_ptr_r[0]] <= tx_word_in;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      wr_ptr_r <= 2'h0;
      rd_ptr_r <= 2'h0;
    end
    else
    begin
      wr_ptr_r <= wr_ptr_r + {1'b0, push};
      rd_ptr_r <= rd_ptr_r + {1'b0, pop};
    end
  end

  // 100 Mbps transmit: symbol select, serialise, scramble, MLT-3
  fel_txst_t tx_st_r;
  fel_txst_t tx_st_nxt;
  logic [4:0] sh_r;
  logic [4:0] sym_nxt;
  logic [2:0] bit_r;
  logic [10:0] scr_r;
  fel_lvl_t mlt_r;
  logic mlt_dir_r;
  wire logic run100 = clk_en_in && speed100_in;
  wire logic sym_end = (bit_r == SYM_LAST);
  wire logic scr_bit = scr_r[SCR_TAP_A] ^ scr_r[SCR_TAP_B];
  wire logic line_bit = sh_r[4] ^ scr_bit;
  wire fel_lvl_t mlt_step = (mlt_r != LVL_ZERO) ? LVL_ZERO :
    (mlt_dir_r ? LVL_POS : LVL_NEG);
  wire logic dir_nxt = (mlt_r == LVL_NEG) ? 1'b1 : (mlt_r == LVL_POS) ? 1'b0 : mlt_dir_r;

  always_comb
  begin
    tx_st_nxt = tx_st_r;
    sym_nxt = SYM_I;
    pop100 = 1'b0;
    case (tx_st_r)
      TX_IDLE:
        if (head_ok)
        begin
          sym_nxt = SYM_J;
          pop100 = sym_end;
          tx_st_nxt = TX_K;
        end
      TX_K:
      begin
        sym_nxt = SYM_K;
        pop100 = sym_end && head_ok;
        tx_st_nxt = TX_DATA;
      end
      TX_DATA:
        if (head_ok)
        begin
          // the J and K groups stand in for the first byte; every later nibble goes through the table
          sym_nxt = ENC_TAB[head.data];
          pop100 = sym_end;
          tx_st_nxt = head.last ? TX_T : TX_DATA;
        end
        else
        begin
          // underrun ends the frame cleanly rather than sending junk
          sym_nxt = SYM_T;
          tx_st_nxt = TX_R;
        end
      TX_T:
      begin
        sym_nxt = SYM_T;
        tx_st_nxt = TX_R;
      end
      TX_R:
      begin
        sym_nxt = SYM_R;
        tx_st_nxt = TX_IDLE;
      end
      default:
        tx_st_nxt = TX_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      tx_st_r <= TX_IDLE;
      sh_r <= SYM_I;
      bit_r <= 3'h0;
      scr_r <= SCR_SEED;
      mlt_r <= LVL_ZERO;
      mlt_dir_r <= 1'b0;
    end
    else if (run100)
    begin
      bit_r <= sym_end ? 3'h0 : bit_r + 3'h1;
      sh_r <= sym_end ? sym_nxt : {sh_r[3:0], 1'b0};
      tx_st_r <= sym_end ? tx_st_nxt : tx_st_r;
      scr_r <= {scr_r[9:0], scr_bit};
      mlt_r <= line_bit ? mlt_step : mlt_r;
      mlt_dir_r <= line_bit ? dir_nxt : mlt_dir_r;
    end
  end
  assign mlt_level_out = mlt_r;

  // 10 Mbps transmit: one Manchester half-bit per enabled cycle
  logic act10_r;
  logic last10_r;
  logic hb_r;
  logic [1:0] nb_r;
  logic [3:0] nsh_r;
  logic man_r;
  logic man_en_r;
  logic weak_r;
  wire logic run10 = clk_en_in && !speed100_in;
  wire logic nib_end = hb_r && (nb_r == NIB_LAST);
  wire logic load10 = !act10_r || (nib_end && !last10_r);
  wire logic half_lvl = hb_r ? nsh_r[0] : !nsh_r[0];
  assign pop10 = !speed100_in && head_ok && load10;

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      act10_r <= 1'b0;
      last10_r <= 1'b0;
      hb_r <= 1'b0;
      nb_r <= 2'h0;
      nsh_r <= 4'h0;
    end
    else if (run10)
    begin
      hb_r <= act10_r && !hb_r;
      nb_r <= (act10_r && hb_r) ? nb_r + 2'h1 : nb_r;
      nsh_r <= (act10_r && hb_r) ? {1'b0, nsh_r[3:1]} : nsh_r;
      if (load10 && head_ok)
      begin
        act10_r <= 1'b1;
        last10_r <= head.last;
        nsh_r <= head.data;
        hb_r <= 1'b0;
        nb_r <= 2'h0;
      end
      else if (nib_end)
      begin
        act10_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      man_r <= 1'b0;
      man_en_r <= 1'b0;
      weak_r <= 1'b0;
    end
    else if (run10)
    begin
      // boundary edge appears only when adjacent bits match
      man_r <= act10_r ? half_lvl : man_r;
      man_en_r <= act10_r;
      // equal to previous half means second half of a wide pulse
      weak_r <= act10_r && man_en_r && (half_lvl == man_r);
    end
  end
  assign man_level_out = man_r;
  assign man_en_out = man_en_r;
  assign man_weak_out = weak_r;

  // 100 Mbps receive: MLT-3 decode, descrambler lock, symbol framing
  fel_lvl_t rx_prev_r;
  logic [10:0] rscr_r;
  logic [4:0] lk_r;
  logic locked_r;
  logic [9:0] rw_r;
  fel_rxst_t rx_st_r;
  fel_rxst_t rx_st_nxt;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic pre_r;
  logic pre_nxt;
  fel_rxw_t rx100_w;
  fel_rxw_t rx_word_r;
  wire logic nrz = (rx_level_in != rx_prev_r);
  wire logic pred = rscr_r[SCR_TAP_A] ^ rscr_r[SCR_TAP_B];
  wire logic key_bit = locked_r ? pred : !nrz;
  wire logic dbit = nrz ^ pred;
  wire logic [9:0] rw_nxt = {rw_r[8:0], dbit};
  wire logic [4:0] sym_rx = rw_nxt[4:0];
  wire logic [4:0] dec = fel_dec(sym_rx);
  wire logic in_frame = (rx_st_r == RX_CHK) || (rx_st_r == RX_FRAME) || (rx_st_r == RX_END);
  wire logic at_sym = (cnt_r == SYM_LAST);

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      rx_prev_r <= LVL_ZERO;
      rscr_r <= SCR_SEED;
      lk_r <= 5'h00;
      locked_r <= 1'b0;
      rw_r <= 10'h3ff;
    end
    else if (run100)
    begin
      rx_prev_r <= rx_level_in;
      rscr_r <= {rscr_r[9:0], key_bit};
      lk_r <= (!locked_r && key_bit == pred && link_ok_in) ? lk_r + 5'h01 : 5'h00;
      locked_r <= link_ok_in && (locked_r || lk_r == LOCK_CNT);
      rw_r <= rw_nxt;
    end
  end
  assign rx_locked_out = locked_r;

  always_comb
  begin
    rx_st_nxt = rx_st_r;
    cnt_nxt = cnt_r + 3'h1;
    pre_nxt = 1'b0;
    rx100_w = '0;
    if (pre_r)
    begin
      rx100_w.valid = 1'b1;
      rx100_w.data = NIB_PRE;
    end
    case (rx_st_r)
      RX_IDLE:
      begin
        cnt_nxt = 3'h0;
        rx_st_nxt = dbit ? RX_IDLE : RX_CHK;
      end
      RX_CHK:
        if (cnt_r == JK_WAIT)
        begin
          cnt_nxt = 3'h0;
          if (rw_nxt == SYM_JK)
          begin
            rx_st_nxt = RX_FRAME;
            rx100_w.valid = 1'b1;
            rx100_w.data = NIB_PRE;
            pre_nxt = 1'b1;
          end
          else
          begin
            rx100_w.err = 1'b1;
            rx_st_nxt = RX_BAD;
          end
        end
      RX_FRAME:
        if (at_sym)
        begin
          cnt_nxt = 3'h0;
          if (dec[4])
          begin
            rx100_w.valid = 1'b1;
            rx100_w.data = dec[3:0];
          end
          else if (sym_rx == SYM_T)
          begin
            rx_st_nxt = RX_END;
          end
          else if (sym_rx == SYM_I)
          begin
            rx100_w.err = 1'b1;
            rx_st_nxt = RX_IDLE;
          end
          else
          begin
            rx100_w.err = 1'b1;
          end
        end
      RX_END:
        if (at_sym)
        begin
          cnt_nxt = 3'h0;
          rx_st_nxt = RX_IDLE;
          rx100_w.err = (sym_rx != SYM_R);
        end
      RX_BAD:
      begin
        cnt_nxt = 3'h0;
        rx_st_nxt = (sym_rx == SYM_I) ? RX_IDLE : RX_BAD;
      end
      default:
        rx_st_nxt = RX_IDLE;
    endcase
    if (!link_ok_in && in_frame)
    begin
      rx100_w.err = 1'b1;
      rx_st_nxt = RX_IDLE;
    end
    else if (!locked_r)
    begin
      rx_st_nxt = RX_IDLE;
    end
  end

  // 10 Mbps receive: second-half sample is the bit value
  logic rhb_r;
  logic [1:0] rnb_r;
  logic [3:0] rnsh_r;
  wire logic [3:0] rnib = {rx_man_in, rnsh_r[3:1]};
  wire logic rx10_v = rx_man_act_in && rhb_r && (rnb_r == NIB_LAST);
  wire fel_rxw_t rx10_w = '{valid: rx10_v, err: 1'b0, data: rnib};

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      rhb_r <= 1'b0;
      rnb_r <= 2'h0;
      rnsh_r <= 4'h0;
    end
    else if (run10)
    begin
      rhb_r <= rx_man_act_in && !rhb_r;
      rnb_r <= !rx_man_act_in ? 2'h0 : rhb_r ? rnb_r + 2'h1 : rnb_r;
      rnsh_r <= (rx_man_act_in && rhb_r) ? rnib : rnsh_r;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      rx_st_r <= RX_IDLE;
      cnt_r <= 3'h0;
      pre_r <= 1'b0;
      rx_word_r <= '0;
    end
    else if (clk_en_in)
    begin
      rx_st_r <= speed100_in ? rx_st_nxt : RX_IDLE;
      cnt_r <= speed100_in ? cnt_nxt : 3'h0;
      pre_r <= speed100_in && pre_nxt;
      rx_word_r <= speed100_in ? rx100_w : rx10_w;
    end
  end
  assign rx_word_out = rx_word_r;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  enc_table_a: assert property (run100 && sym_end && tx_st_r == TX_DATA && head_ok
    |=> sh_r == ENC_TAB[$past(head.data)]) else $error("data group mismatch");
  idle_fill_a: assert property (run100 && sym_end && tx_st_r == TX_IDLE && !head_ok
    |=> sh_r == SYM_I) else $error("idle group missing");
  start_pair_a: assert property (run100 && sym_end && tx_st_r == TX_IDLE && head_ok
    |=> sh_r == SYM_J && tx_st_r == TX_K) else $error("start pair wrong");
  end_pair_a: assert property (run100 && sym_end && tx_st_r == TX_T
    |=> sh_r == SYM_T && tx_st_r == TX_R) else $error("end pair wrong");
  scr_seq_a: assert property (run100 |=> scr_r[0] == ($past(scr_r[10]) ^ $past(scr_r[8])))
    else $error("scrambler sequence wrong");
  mlt_hold_a: assert property (run100 && !line_bit |=> $stable(mlt_r))
    else $error("level moved on zero");
  mlt_cycle_a: assert property (run100 && line_bit && mlt_r == LVL_POS
    |=> mlt_r == LVL_ZERO ##0 (!run100 || !line_bit || mlt_step == LVL_NEG))
    else $error("level order wrong");
  rx_invalid_a: assert property (run100 && locked_r && link_ok_in && rx_st_r == RX_FRAME
    && at_sym && !dec[4] && sym_rx != SYM_T |=> rx_word_out.err) else $error("invalid missed");
  rx_link_a: assert property (run100 && in_frame && !link_ok_in
    |=> rx_word_out.err && rx_st_r == RX_IDLE) else $error("link loss missed");
  rx_start_a: assert property (run100 && locked_r && link_ok_in && rx_st_r == RX_CHK
    && cnt_r == JK_WAIT && rw_nxt != SYM_JK |=> rx_word_out.err)
    else $error("start pair missed");
  // one clock back is the first half, whatever the strobe pattern
  man_mid_a: assert property (run10 && act10_r && hb_r && man_en_r
    |=> man_r != $past(man_r)) else $error("no mid-bit edge");

  frame_sent_c: cover property (run100 && tx_st_r == TX_R && sym_end);
  frame_rcvd_c: cover property (run100 && rx_st_r == RX_END && at_sym && sym_rx == SYM_R);
  weak_half_c: cover property (run10 && weak_r);
  rx10_nib_c: cover property (run10 && rx10_v);
endmodule // fel_line_coder

//--- tb/fel_mac_model.sv
// fel_mac_model: nibble-side controller model feeding one frame per start pulse
module fel_mac_model (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic ready_in,
  input wire logic start_in,
  input wire logic slow_in,
  input wire logic [5:0] len_in,
  input wire logic [3:0] base_in,
  output logic valid_out,
  output fel_pkg::fel_txw_t word_out,
  output logic busy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import fel_pkg::*;
  logic [5:0] idx_r;
  logic gap_r;
  logic take;
  logic [3:0] nib;
  // first byte is preamble 0101 0101, the rest a counting pattern
  assign nib = (idx_r < 6'h02) ? 4'h5 : base_in + idx_r[3:0];
  assign valid_out = busy_out && !gap_r;
  // released bus shows the inverse, never a stale nibble
  assign word_out = valid_out ? {idx_r == len_in - 6'h01, nib} : {1'b1, ~nib};
  assign take = valid_out && ready_in && clk_en_in;
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      busy_out <= 1'b0;
      idx_r <= 6'h00;
      gap_r <= 1'b0;
    end
    else
    begin
      gap_r <= take && slow_in;
      if (start_in && !busy_out)
      begin
        busy_out <= 1'b1;
        idx_r <= 6'h00;
      end
      else if (take)
      begin
        idx_r <= idx_r + 6'h01;
        busy_out <= !word_out.last;
      end
    end
  end
endmodule // fel_mac_model

//--- tb/fel_line_coder_tb.sv
// fel_line_coder_tb: loopback frame rows, then injected line faults
module fel_line_coder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fel_pkg::*;
  typedef struct {logic spd; logic slow; logic [5:0] len; logic [3:0] base;} fel_row_t;
  fel_row_t rows [4] = '{'{1'b1, 1'b0, 6'h12, 4'h0}, '{1'b1, 1'b1, 6'h05, 4'h7},
    '{1'b0, 1'b0, 6'h06, 4'h3}, '{1'b0, 1'b1, 6'h04, 4'hc}};
  logic clk_in = 1'b0;
  logic reset_in = 1'b0;
  logic en = 1'b1;
  logic spd = 1'b1;
  logic link = 1'b1;
  logic start = 1'b0;
  logic slow = 1'b0;
  logic own = 1'b0;
  logic full = 1'b0;
  logic mprv = 1'b0;
  logic [5:0] len = 6'h01;
  logic [3:0] base = 4'h0;
  logic [10:0] sc = 11'h155;
  logic tx_valid, tx_ready, man_lvl, man_en, man_weak, locked, busy;
  fel_txw_t tx_word;
  fel_lvl_t mlt, rx_lvl, prv, lnz;
  fel_lvl_t onz = LVL_POS;
  fel_lvl_t own_lvl = LVL_ZERO;
  fel_rxw_t rxw;
  int num_errors = 0;
  int n_tests = 0;
  int nerr = 0;
  int run = 0;
  int e0;
  logic [3:0] rxq [$];
  assign rx_lvl = own ? own_lvl : mlt;

  fel_line_coder uut (.clk_in(clk_in), .reset_in(reset_in), .clk_en_in(en), .speed100_in(spd),
    .link_ok_in(link), .tx_valid_in(tx_valid), .tx_word_in(tx_word), .tx_ready_out(tx_ready),
    .mlt_level_out(mlt), .man_level_out(man_lvl), .man_en_out(man_en), .man_weak_out(man_weak),
    .rx_level_in(rx_lvl), .rx_man_in(man_lvl), .rx_man_act_in(man_en), .rx_word_out(rxw),
    .rx_locked_out(locked));
  fel_mac_model mac (.clk_in(clk_in), .reset_in(reset_in), .clk_en_in(en), .ready_in(tx_ready),
    .start_in(start), .slow_in(slow), .len_in(len), .base_in(base), .valid_out(tx_valid),
    .word_out(tx_word), .busy_out(busy));

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // far-end transmitter: own scrambler and three-level coder, one bit per cycle
  task automatic sym(input logic [4:0] s);
    logic b;
    for (int i = 4; i >= 0; i--)
    begin
      @(posedge clk_in);
      b = s[i] ^ sc[10] ^ sc[8];
      sc = {sc[9:0], sc[10] ^ sc[8]};
      if (b && own_lvl != LVL_ZERO)
      begin
        onz = own_lvl;
        own_lvl <= LVL_ZERO;
      end
      else if (b)
        own_lvl <= (onz == LVL_POS) ? LVL_NEG : LVL_POS;
    end
  endtask

  initial
  begin
    forever #10 clk_in = ~clk_in;
  end

  // 10 Mbps rows strobe the enable to exercise the frozen cycles
  always @(posedge clk_in) en <= spd ? 1'b1 : ~en;

  always @(posedge clk_in)
  begin
    if (reset_in)
    begin
      prv = LVL_ZERO;
      lnz = LVL_POS;
    end
    else if (mlt !== prv)
    begin
      chk("mlt step", (prv != LVL_ZERO) ? LVL_ZERO :
        (lnz == LVL_POS) ? LVL_NEG : LVL_POS, mlt);
      if (prv != LVL_ZERO) lnz = prv;
      prv = mlt;
    end
    if (!tx_ready) full = 1'b1;
    if (en && rxw.err === 1'b1) nerr++;
    if (en && rxw.valid === 1'b1 && rxw.err !== 1'b1) rxq.push_back(rxw.data);
    if (en && man_en && !spd)
    begin
      run = (man_lvl === mprv) ? run + 1 : 1;
      chk("man run", 8'h01, run <= 2);
      chk("man weak", run == 2, man_weak);
      mprv = man_lvl;
    end
    else if (!man_en) run = 0;
  end

  initial
  begin
    reset_in = 1'b1;
    repeat (20) @(posedge clk_in);
    @(negedge clk_in);
    chk("ready rst", 8'h01, tx_ready);
    chk("mlt rst", LVL_ZERO, mlt);
    chk("rx rst", 8'h00, {rxw, locked});
    @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (80) @(posedge clk_in);
    chk("lock", 8'h01, locked);
    foreach (rows[r])
    begin
      spd <= rows[r].spd;
      slow <= rows[r].slow;
      len <= rows[r].len;
      base <= rows[r].base;
      repeat (60) @(posedge clk_in);
      rxq.delete();
      start <= 1'b1;
      @(posedge clk_in);
      start <= 1'b0;
      @(negedge clk_in);
      for (int t = 0; t < 400 && busy !== 1'b0; t++) @(negedge clk_in);
      chk("mac done", 8'h00, busy);
      repeat (100) @(posedge clk_in);
      chk("rx count", rows[r].len, rxq.size());
      foreach (rxq[k]) chk("rx nibble", (k < 2) ? 4'h5 : rows[r].base + 4'(k), rxq[k]);
    end
    chk("buf full", 8'h01, full);
    chk("rx err", 8'h00, nerr);
    spd <= 1'b1;
    own <= 1'b1;
    link <= 1'b0;
    // two edges: the first may still fall in a frozen slot of the strobe
    repeat (2) @(posedge clk_in);
    link <= 1'b1;
    repeat (12) sym(SYM_I);
    chk("own lock", 8'h01, locked);
    rxq.delete();
    e0 = nerr;
    sym(SYM_J);
    sym(SYM_K);
    sym(ENC_TAB[9]);
    sym(5'h00);
    sym(5'h01);
    sym(5'h19);
    repeat (5) sym(SYM_I);
    chk("bad groups", e0 + 4, nerr);
    chk("rx data", 8'h03, rxq.size());
    chk("rx nine", 8'h09, rxq[2]);
    e0 = nerr;
    sym(SYM_J);
    sym(ENC_TAB[0]);
    repeat (4) sym(SYM_I);
    chk("bad start", e0 + 1, nerr);
    e0 = nerr;
    sym(SYM_J);
    sym(SYM_K);
    sym(SYM_T);
    repeat (4) sym(SYM_I);
    chk("bad end", e0 + 1, nerr);
    e0 = nerr;
    sym(SYM_J);
    sym(SYM_K);
    sym(ENC_TAB[3]);
    link <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk("link loss", e0 + 1, nerr);
    chk("lock lost", 8'h00, locked);
    end_of_test();
  end

  initial
  begin
    repeat (20000) @(posedge clk_in);
    num_errors++;
    end_of_test();
  end
endmodule // fel_line_coder_tb
